/* File: hw/overtemp_pin_cfg_pkg.sv */
package overtemp_pin_cfg_pkg;

  // Register byte addresses on the Wishbone bus (offsets as printed are bytes).
  localparam logic [7:0] ADDR_FORMAT_CFG    = 8'h7C;
  localparam logic [7:0] ADDR_PIN_CFG       = 8'h7D;
  localparam logic [7:0] ADDR_TEST_ONE      = 8'h7E;
  localparam logic [7:0] ADDR_TEST_TWO      = 8'h7F;
  localparam logic [7:0] ADDR_LOCK_CFG      = 8'h40;

  // Reset values.
  localparam logic [7:0] RST_FORMAT_CFG     = 8'h00;
  localparam logic [7:0] RST_PIN_CFG        = 8'h00;
  localparam logic [7:0] RST_TEST           = 8'h00;

  // Field positions in the channel and format register.
  localparam int FMT_TWOS_BIT               = 0;
  localparam int FMT_R2_OVERTEMP_BIT        = 7;

  // Field positions in the pin and alarm register.
  localparam int PIN_FUNC_LSB               = 0;
  localparam int PIN_OFF_BIT                = 2;
  localparam int PIN_RESP_BIT               = 3;
  localparam int PIN_BYPASS_BIT             = 6;
  localparam logic [7:0] PIN_WRITE_MASK     = 8'h4F;

  // Lock register field.
  localparam int LOCK_BIT                   = 1;

  // Disabling limit codes in each temperature format, and the full fan speed code.
  localparam logic [7:0] LIMIT_OFF_OFFSET64 = 8'h00;
  localparam logic [7:0] LIMIT_OFF_TWOS     = 8'h80;
  localparam logic [7:0] FULL_SPEED         = 8'hFF;

  // Multi-function pin roles.
  typedef enum logic [1:0] {
    PIN_FAN4_SPEED = 2'b00,
    PIN_OVERTEMP   = 2'b01,
    PIN_ALERT      = 2'b10,
    PIN_GPIO       = 2'b11
  } pin_role_t;

endpackage

/* File: hw/overtemp_compare.sv */
`timescale 1ns/1ps
module overtemp_compare (
  // Reading and limit.
  input  wire logic [7:0] reading,
  input  wire logic [7:0] limit,
  input  wire logic       twos_format,
  // Result.
  output logic            exceeded
);

  logic limit_off;
  logic [7:0] r_cmp;
  logic [7:0] l_cmp;

  // The minimum code of the active format turns the channel off.
  always_comb begin
    limit_off = twos_format ? (limit == overtemp_pin_cfg_pkg::LIMIT_OFF_TWOS)
                            : (limit == overtemp_pin_cfg_pkg::LIMIT_OFF_OFFSET64);
    // Flipping the sign bit maps two's complement onto an unsigned compare.
    r_cmp = twos_format ? {~reading[7], reading[6:0]} : reading;
    l_cmp = twos_format ? {~limit[7], limit[6:0]} : limit;
    exceeded = !limit_off && (r_cmp > l_cmp);
  end

endmodule

/* File: hw/thermal_fan_config_regs.sv */
`timescale 1ns/1ps
module thermal_fan_config_regs (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Wishbone slave.
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  // Remote channel 2 reading and its over-temperature limit.
  input  wire logic [7:0] remote2_reading,
  input  wire logic [7:0] remote2_limit,
  // Programmed maximum fan speeds.
  input  wire logic [7:0] fan1_max_speed,
  input  wire logic [7:0] fan2_max_speed,
  input  wire logic [7:0] fan3_max_speed,
  // Shared over-temperature pin, active low.
  input  wire logic       overtemp_pin_in_n,
  output logic            overtemp_pin_out_n,
  output logic            overtemp_pin_oe,
  // Multi-function pin roles and the timer input.
  output logic            fan4_speed_input_sel,
  output logic            multi_pin_overtemp_sel,
  output logic            multi_pin_alert_sel,
  output logic            multi_pin_gpio_sel,
  output logic            overtemp_timer_in,
  // Fan demand and core voltage scale.
  output logic [7:0]      fan1_speed_demand_q,
  output logic [7:0]      fan2_speed_demand_q,
  output logic [7:0]      fan3_speed_demand_q,
  output logic            core_voltage_attenuator_bypass,
  output logic            temperature_format_select
);

  logic [7:0] format_cfg_q;
  logic [7:0] pin_cfg_q;
  logic       lock_q;
  logic       ack_q;
  logic [31:0] rdata_q;
  logic       access;
  logic       wr_en;
  logic       remote2_hot;
  logic       overtemp_active;
  logic [7:0] max_speed [3];
  logic [7:0] demand_d [3];
  logic [1:0] multi_pin_function_select;

  // A single-cycle answer: ack follows one edge after the request and drops after one cycle.
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_en  = access && wb_we_i && wb_sel_i[0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Bus acknowledge.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  // The lock is sticky until reset; software cannot clear it.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (wr_en && wb_adr_i == overtemp_pin_cfg_pkg::ADDR_LOCK_CFG && wb_dat_i[overtemp_pin_cfg_pkg::LOCK_BIT]) begin
      lock_q <= 1'b1;
    end
  end

  // Configuration writes are dropped while locked.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      format_cfg_q <= overtemp_pin_cfg_pkg::RST_FORMAT_CFG;
      pin_cfg_q    <= overtemp_pin_cfg_pkg::RST_PIN_CFG;
    end else if (wr_en && !lock_q) begin
      if (wb_adr_i == overtemp_pin_cfg_pkg::ADDR_FORMAT_CFG) begin
        format_cfg_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i == overtemp_pin_cfg_pkg::ADDR_PIN_CFG) begin
        pin_cfg_q <= wb_dat_i[7:0] & overtemp_pin_cfg_pkg::PIN_WRITE_MASK;
      end
    end
  end

  // Read data; test registers always return their zero reset value.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (access && !wb_we_i) begin
      case (wb_adr_i)
        overtemp_pin_cfg_pkg::ADDR_FORMAT_CFG: rdata_q <= {24'h00_0000, format_cfg_q};
        overtemp_pin_cfg_pkg::ADDR_PIN_CFG:    rdata_q <= {24'h00_0000, pin_cfg_q};
        overtemp_pin_cfg_pkg::ADDR_TEST_ONE:   rdata_q <= {24'h00_0000, overtemp_pin_cfg_pkg::RST_TEST};
        overtemp_pin_cfg_pkg::ADDR_TEST_TWO:   rdata_q <= {24'h00_0000, overtemp_pin_cfg_pkg::RST_TEST};
        overtemp_pin_cfg_pkg::ADDR_LOCK_CFG:   rdata_q <= {30'h0000_0000, lock_q, 1'b0};
        default:                        rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Limit comparison for remote channel 2.
  overtemp_compare u_remote2_cmp (
    .reading     (remote2_reading),
    .limit       (remote2_limit),
    .twos_format (format_cfg_q[overtemp_pin_cfg_pkg::FMT_TWOS_BIT]),
    .exceeded    (remote2_hot)
  );

  // The pin is driven only when the channel is enabled and the feature is on.
  always_comb begin
    overtemp_active = remote2_hot && format_cfg_q[overtemp_pin_cfg_pkg::FMT_R2_OVERTEMP_BIT]
                      && !pin_cfg_q[overtemp_pin_cfg_pkg::PIN_OFF_BIT];
    overtemp_pin_oe    = overtemp_active;
    overtemp_pin_out_n = 1'b0;
    overtemp_timer_in  = !overtemp_pin_in_n && !pin_cfg_q[overtemp_pin_cfg_pkg::PIN_OFF_BIT];
  end

  // Pin role decode.
  assign multi_pin_function_select = pin_cfg_q[overtemp_pin_cfg_pkg::PIN_FUNC_LSB +: 2];
  assign fan4_speed_input_sel   = multi_pin_function_select == overtemp_pin_cfg_pkg::PIN_FAN4_SPEED;
  assign multi_pin_overtemp_sel = multi_pin_function_select == overtemp_pin_cfg_pkg::PIN_OVERTEMP;
  assign multi_pin_alert_sel    = multi_pin_function_select == overtemp_pin_cfg_pkg::PIN_ALERT;
  assign multi_pin_gpio_sel     = multi_pin_function_select == overtemp_pin_cfg_pkg::PIN_GPIO;
  assign core_voltage_attenuator_bypass = pin_cfg_q[overtemp_pin_cfg_pkg::PIN_BYPASS_BIT];
  assign temperature_format_select      = format_cfg_q[overtemp_pin_cfg_pkg::FMT_TWOS_BIT];

  // Fan override demand; zero means the normal control loop owns the fan.
  assign max_speed[0] = fan1_max_speed;
  assign max_speed[1] = fan2_max_speed;
  assign max_speed[2] = fan3_max_speed;

  for (genvar i = 0; i < 3; i++) begin : g_fan
    always_comb begin
      if (!overtemp_active) begin
        demand_d[i] = 8'h00;
      end else if (pin_cfg_q[overtemp_pin_cfg_pkg::PIN_RESP_BIT]) begin
        demand_d[i] = max_speed[i];
      end else begin
        demand_d[i] = overtemp_pin_cfg_pkg::FULL_SPEED;
      end
    end
  end

  // Demands are registered so the fan outputs are glitch free.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fan1_speed_demand_q <= 8'h00;
      fan2_speed_demand_q <= 8'h00;
      fan3_speed_demand_q <= 8'h00;
    end else begin
      fan1_speed_demand_q <= demand_d[0];
      fan2_speed_demand_q <= demand_d[1];
      fan3_speed_demand_q <= demand_d[2];
    end
  end

  // The lock only ever sets, and while it is set neither configuration register may move.
  AST_LOCK_HOLDS: assert property (@(posedge ref_clk) disable iff (rst)
    lock_q && wr_en && wb_adr_i == overtemp_pin_cfg_pkg::ADDR_PIN_CFG |=> $stable(pin_cfg_q))
    else $error("Locked pin register changed.");

  AST_LOCK_FORMAT: assert property (@(posedge ref_clk) disable iff (rst)
    lock_q |=> $stable(format_cfg_q))
    else $error("Locked format register changed.");

  AST_LOCK_SET: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en && wb_adr_i == overtemp_pin_cfg_pkg::ADDR_LOCK_CFG && wb_dat_i[overtemp_pin_cfg_pkg::LOCK_BIT] |=> lock_q)
    else $error("Lock bit write did not lock.");

  AST_LOCK_STICKY: assert property (@(posedge ref_clk) disable iff (rst)
    lock_q |=> lock_q)
    else $error("Lock cleared without reset.");

  // Register contents and read data; a stale read word would hide a broken mask.
  AST_UNUSED_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    (pin_cfg_q & ~overtemp_pin_cfg_pkg::PIN_WRITE_MASK) == 8'h00)
    else $error("Unused pin register bits set.");

  AST_PIN_READBACK: assert property (@(posedge ref_clk) disable iff (rst)
    access && !wb_we_i && wb_adr_i == overtemp_pin_cfg_pkg::ADDR_PIN_CFG
    |=> wb_dat_o == {24'h00_0000, $past(pin_cfg_q)})
    else $error("Pin register read data wrong.");

  AST_FORMAT_READBACK: assert property (@(posedge ref_clk) disable iff (rst)
    access && !wb_we_i && wb_adr_i == overtemp_pin_cfg_pkg::ADDR_FORMAT_CFG
    |=> wb_dat_o == {24'h00_0000, $past(format_cfg_q)})
    else $error("Format register read data wrong.");

  AST_TEST_READ_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    access && !wb_we_i && wb_adr_i == overtemp_pin_cfg_pkg::ADDR_TEST_ONE |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("Test register read not zero.");

  AST_TEST_TWO_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    access && !wb_we_i && wb_adr_i == overtemp_pin_cfg_pkg::ADDR_TEST_TWO |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("Second test register read not zero.");

  AST_READ_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("Read data upper bytes not zero.");

  // Bus handshake: every taken request is answered exactly one cycle later, and only then.
  AST_ACK_AFTER_REQ: assert property (@(posedge ref_clk) disable iff (rst)
    access |=> wb_ack_o)
    else $error("Request not acknowledged.");

  AST_NO_ACK_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("Ack without a request.");

  AST_ACK_ONE: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack held two cycles.");

  // Pin roles and the plain configuration outputs.
  AST_ROLE_ONEHOT: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot({fan4_speed_input_sel, multi_pin_overtemp_sel, multi_pin_alert_sel, multi_pin_gpio_sel}))
    else $error("Multi-function pin role not one-hot.");

  AST_BYPASS_FOLLOWS: assert property (@(posedge ref_clk) disable iff (rst)
    core_voltage_attenuator_bypass == pin_cfg_q[overtemp_pin_cfg_pkg::PIN_BYPASS_BIT])
    else $error("Attenuator bypass output wrong.");

  AST_FORMAT_FOLLOWS: assert property (@(posedge ref_clk) disable iff (rst)
    temperature_format_select == format_cfg_q[overtemp_pin_cfg_pkg::FMT_TWOS_BIT])
    else $error("Format select output wrong.");

  // Limit comparison in both temperature formats.
  AST_MIN_LIMIT_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    remote2_limit == (format_cfg_q[overtemp_pin_cfg_pkg::FMT_TWOS_BIT] ? overtemp_pin_cfg_pkg::LIMIT_OFF_TWOS
                                                                 : overtemp_pin_cfg_pkg::LIMIT_OFF_OFFSET64)
    |-> !overtemp_pin_oe)
    else $error("Disabled limit still drives pin.");

  AST_LIMIT_OFF_TWOS: assert property (@(posedge ref_clk) disable iff (rst)
    format_cfg_q[overtemp_pin_cfg_pkg::FMT_TWOS_BIT] && remote2_limit == overtemp_pin_cfg_pkg::LIMIT_OFF_TWOS |-> !remote2_hot)
    else $error("Two's complement minimum limit not disabling.");

  AST_LIMIT_OFF_OFFSET: assert property (@(posedge ref_clk) disable iff (rst)
    !format_cfg_q[overtemp_pin_cfg_pkg::FMT_TWOS_BIT] && remote2_limit == overtemp_pin_cfg_pkg::LIMIT_OFF_OFFSET64
    |-> !remote2_hot)
    else $error("Offset minimum limit not disabling.");

  AST_TWOS_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
    format_cfg_q[overtemp_pin_cfg_pkg::FMT_TWOS_BIT] && remote2_reading[7] && !remote2_limit[7] |-> !remote2_hot)
    else $error("Negative reading beat a positive limit.");

  AST_OFFSET_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
    !format_cfg_q[overtemp_pin_cfg_pkg::FMT_TWOS_BIT] && remote2_reading > remote2_limit
    && remote2_limit != overtemp_pin_cfg_pkg::LIMIT_OFF_OFFSET64 |-> remote2_hot)
    else $error("Offset reading over limit not seen.");

  // Shared pin: driven low only for a hot, enabled channel with the feature on.
  AST_PIN_DRIVE: assert property (@(posedge ref_clk) disable iff (rst)
    overtemp_pin_oe |-> format_cfg_q[overtemp_pin_cfg_pkg::FMT_R2_OVERTEMP_BIT])
    else $error("Pin driven with channel disabled.");

  AST_PIN_NEEDS_HOT: assert property (@(posedge ref_clk) disable iff (rst)
    overtemp_pin_oe |-> remote2_hot)
    else $error("Pin driven without an over-limit reading.");

  AST_PIN_DRIVES: assert property (@(posedge ref_clk) disable iff (rst)
    format_cfg_q[overtemp_pin_cfg_pkg::FMT_R2_OVERTEMP_BIT] && remote2_hot && !pin_cfg_q[overtemp_pin_cfg_pkg::PIN_OFF_BIT]
    |-> overtemp_pin_oe)
    else $error("Hot enabled channel did not drive the pin.");

  AST_PIN_LOW_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
    overtemp_pin_oe |-> !overtemp_pin_out_n)
    else $error("Pin driven high.");

  AST_FEATURE_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    pin_cfg_q[overtemp_pin_cfg_pkg::PIN_OFF_BIT] |-> !overtemp_pin_oe ##1 fan1_speed_demand_q == 8'h00)
    else $error("Over-temperature acted while disabled.");

  AST_TIMER_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    pin_cfg_q[overtemp_pin_cfg_pkg::PIN_OFF_BIT] |-> !overtemp_timer_in)
    else $error("Timer input live while feature off.");

  // Fan response, one cycle after the over-temperature state is seen.
  AST_FULL_SPEED: assert property (@(posedge ref_clk) disable iff (rst)
    overtemp_active && !pin_cfg_q[overtemp_pin_cfg_pkg::PIN_RESP_BIT] |=> fan2_speed_demand_q == 8'hFF)
    else $error("Fans not at full speed.");

  AST_FULL_SPEED_REST: assert property (@(posedge ref_clk) disable iff (rst)
    overtemp_active && !pin_cfg_q[overtemp_pin_cfg_pkg::PIN_RESP_BIT]
    |=> fan1_speed_demand_q == 8'hFF && fan3_speed_demand_q == 8'hFF)
    else $error("Fans one and three not at full speed.");

  AST_MAX_SPEED: assert property (@(posedge ref_clk) disable iff (rst)
    overtemp_active && pin_cfg_q[overtemp_pin_cfg_pkg::PIN_RESP_BIT] |=> fan3_speed_demand_q == $past(fan3_max_speed))
    else $error("Fans not at programmed maximum.");

  AST_MAX_SPEED_REST: assert property (@(posedge ref_clk) disable iff (rst)
    overtemp_active && pin_cfg_q[overtemp_pin_cfg_pkg::PIN_RESP_BIT]
    |=> fan1_speed_demand_q == $past(fan1_max_speed) && fan2_speed_demand_q == $past(fan2_max_speed))
    else $error("Fans one and two not at programmed maximum.");

  AST_NO_OVERRIDE: assert property (@(posedge ref_clk) disable iff (rst)
    !overtemp_active
    |=> fan1_speed_demand_q == 8'h00 && fan2_speed_demand_q == 8'h00 && fan3_speed_demand_q == 8'h00)
    else $error("Fan override without over-temperature.");

endmodule

/* File: testbench/wb_host_model.sv */
`timescale 1ns/1ps
module wb_host_model (
  // Bus clock.
  input  wire logic        ref_clk,
  // Wishbone master side.
  output logic             wb_cyc,
  output logic             wb_stb,
  output logic             wb_we,
  output logic [7:0]       wb_adr,
  output logic [3:0]       wb_sel,
  output logic [31:0]      wb_wdat,
  input  wire logic [31:0] wb_rdat,
  input  wire logic        wb_ack
);
  // The bus is idle from time zero.
  initial begin
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_wdat = 32'h0000_0000;
  end

  // One classic cycle; the request stands until ack is seen at an edge, since the slave may answer late.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'h1;
    wb_wdat <= {24'h00_0000, d};
    do @(posedge ref_clk); while (wb_ack !== 1'b1);
    r = wb_rdat;
    {wb_cyc, wb_stb, wb_we} <= 3'h0;
    @(posedge ref_clk);
  endtask
endmodule

/* File: testbench/thermal_fan_config_regs_test.sv */
`timescale 1ns/1ps
module thermal_fan_config_regs_test;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack, oe, out_n, t_in, byp, fmt;
  logic [7:0]  adr, d1, d2, d3;
  logic [3:0]  sel;
  wire  [3:0]  role;
  logic [31:0] wdat, rdat, rd;
  logic [7:0]  rdg = 8'h00;
  logic [7:0]  lim = 8'h00;
  logic        ext_n = 1'b1;
  wire         pin_n = (oe === 1'b1) ? out_n : ext_n;
  int          n_fail = 0;
  int          check_count = 0;

  // Free running clock.
  always #2.5 ref_clk = ~ref_clk;

  // Block under test and the bus master facing it.
  thermal_fan_config_regs DUT (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .remote2_reading(rdg),
    .remote2_limit(lim), .fan1_max_speed(8'h31), .fan2_max_speed(8'h62), .fan3_max_speed(8'h93),
    .overtemp_pin_in_n(pin_n), .overtemp_pin_out_n(out_n), .overtemp_pin_oe(oe), .fan4_speed_input_sel(role[0]),
    .multi_pin_overtemp_sel(role[1]), .multi_pin_alert_sel(role[2]), .multi_pin_gpio_sel(role[3]),
    .overtemp_timer_in(t_in), .fan1_speed_demand_q(d1), .fan2_speed_demand_q(d2), .fan3_speed_demand_q(d3),
    .core_voltage_attenuator_bypass(byp), .temperature_format_select(fmt));
  wb_host_model HOST (.ref_clk(ref_clk), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel),
    .wb_wdat(wdat), .wb_rdat(rdat), .wb_ack(ack));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    HOST.access(1'b1, a, d, rd);
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    HOST.access(1'b0, a, 8'h00, rd);
    chk(what, exp, rd);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Reset values, field masks, pin roles and the read-only test registers.
  task automatic test_regs;
    rdchk("fmt", 8'h7c, 32'h0000_0000);
    rdchk("pin", 8'h7d, 32'h0000_0000);
    rdchk("t1", 8'h7e, 32'h0000_0000);
    chk("role", 4'h1, role);
    wr(8'h7d, 8'hff);
    rdchk("pin", 8'h7d, 32'h0000_004f);
    chk("byp", 1'b1, byp);
    for (int i = 0; i < 4; i++) begin
      wr(8'h7d, 8'(i));
      chk("role", 4'h1 << i, role);
    end
    wr(8'h7e, 8'ha5);
    rdchk("t1", 8'h7e, 32'h0000_0000);
    wr(8'h7f, 8'h5a);
    rdchk("t2", 8'h7f, 32'h0000_0000);
  endtask

  // Format, remote-2 pin drive, fan response, disabling limits and feature off.
  task automatic test_overtemp;
    rdg <= 8'h90;
    lim <= 8'h10;
    wr(8'h7d, 8'h00);
    wr(8'h7c, 8'h81);
    chk("fmt", 1'b1, fmt);
    chk("oe", 1'b0, oe);
    wr(8'h7c, 8'h80);
    chk("oe", 1'b1, oe);
    chk("out_n", 1'b0, out_n);
    chk("tin", 1'b1, t_in);
    chk("dm", 24'hff_ffff, {d3, d2, d1});
    wr(8'h7d, 8'h08);
    chk("dm", 24'h93_6231, {d3, d2, d1});
    lim <= 8'h00;
    repeat (2) @(posedge ref_clk);
    chk("oe", 1'b0, oe);
    lim <= 8'h10;
    ext_n <= 1'b0;
    wr(8'h7c, 8'h00);
    chk("oe", 1'b0, oe);
    chk("tin", 1'b1, t_in);
    wr(8'h7d, 8'h04);
    chk("tin", 1'b0, t_in);
    ext_n <= 1'b1;
    wr(8'h7c, 8'h80);
    chk("oe", 1'b0, oe);
    wr(8'h7d, 8'h00);
    rdg <= 8'h10;
    lim <= 8'h80;
    wr(8'h7c, 8'h81);
    chk("oe", 1'b0, oe);
  endtask

  // After locking, both configuration registers keep their contents.
  task automatic test_lock;
    wr(8'h40, 8'h02);
    rdchk("lock", 8'h40, 32'h0000_0002);
    wr(8'h7c, 8'h00);
    rdchk("fmt", 8'h7c, 32'h0000_0081);
    wr(8'h7d, 8'h4f);
    rdchk("pin", 8'h7d, 32'h0000_0000);
  endtask

  // Watchdog against a hung handshake.
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    test_regs();
    test_overtemp();
    test_lock();
    tally_and_finish();
  end
endmodule
